// [core/mcic_ctrl.v]
// Interrupt controller: detection, priority, entry and return sequence.
// Summary of operation
// - NMI pin falling edge, vector 0 FFCH.
// - Port A vector 1, edge or level.
// - Port B/C vector 2, falling or rising.
// - Timer vector 3 FF2H, ADC vector 4 FF0H.
// - Peripheral flag requests only when mask set.
// - NMI preempts normal and maskable code; maskables never nest.
// - Fixed priority, vector 0 highest.
// - Option register at C8H, write-only.
// - Bit 4 globally enables all, NMI included.
// - Bit 5 selects rising edge for vector 2.
// - Bit 6 selects low level for vector 1.
// - Other option bits have no function.
// - NMI edge latch cleared on service entry.
// - Edge mode stores one request, drops more.
// - Level mode stores nothing; pin held low.
// - Lines tested at each instruction end.
// - Carry/zero banked per context, auto switched.
// - Entry: flags, push PC, inhibit, clear, vector.
// - Return restores flags and pops PC.
// - Timer zero flag requests when enabled.
// - Conversion complete flag requests when enabled.
// - Reset starts in NMI context.
`timescale 1ns/10ps
`include "mcic_defs.vh"
//
// The controller sits between the pins, the peripherals and the core's
// instruction sequencer. It watches five request sources, decides at the
// end of each instruction whether one of them is taken, and then drives
// the entry sequence: the flag bank is switched, the return address is
// pushed, the maskable lines are inhibited, the edge latch of the chosen
// source is cleared and the vector address is presented to the core.
//
// The non-maskable pin and the two port groups are sampled once per clock.
// Their previous levels are kept so that an edge is seen as a difference
// between two samples. Edge requests are stored in one latch per vector,
// so a burst of edges while a routine runs leaves exactly one request.
//
// Port A can instead be level sensitive. In that mode nothing is stored:
// the request is simply any port A pin low at the instruction end, so a
// source that lets go of its pin too early is never served.
//
// The timer and converter flags arrive as levels from their peripherals.
// They are gated by their own enables and are cleared by the peripheral,
// never here, because the routine has to read the flag to poll it.
//
// The context register tells which of the three flag banks is in use.
// A stack of contexts, at most two deep, lets a non-maskable routine
// interrupt a maskable one and then hand control back to it cleanly.
//
// After reset the block starts in non-maskable context with nothing to
// return to, so the restart routine must end with a return before any
// maskable source is taken. That return lands in normal context.
//
// The global enable gates everything, the non-maskable source included.
// A non-maskable edge seen while it is cleared stays in its latch and is
// served once software sets the enable again.
//
module mcic_ctrl #(
    parameter PA_W  = 8,
    parameter PBC_W = 16
) (
    input  wire             i_core_clk,
    input  wire             i_srst,
    input  wire             i_nmi_pin,
    input  wire [PA_W-1:0]  i_porta_pins,
    input  wire [PBC_W-1:0] i_portbc_pins,
    input  wire             i_timer_zero_flag,
    input  wire             i_timer_irq_enable,
    input  wire             i_adc_eoc_flag,
    input  wire             i_adc_irq_enable,
    input  wire             i_data_wr,
    input  wire [7:0]       i_data_addr,
    input  wire [7:0]       i_data_wdata,
    input  wire             i_instr_end,
    input  wire             i_return_from_interrupt,
    input  wire [11:0]      i_next_pc,
    input  wire             i_flag_wr,
    input  wire             i_carry_in,
    input  wire             i_zero_in,
    output wire             o_irq_take,
    output reg  [11:0]      o_vector_q,
    output reg              o_vector_load_q,
    output wire [11:0]      o_return_pc,
    output reg              o_return_load_q,
    output wire             o_carry,
    output wire             o_zero,
    output reg  [1:0]       o_context_q
);
    // Write-only option register; only bits 4..6 kept.
    reg [7:0]       interrupt_option_reg_q;
    reg             nmi_pin_q;             // Previous NMI level.
    reg [PA_W-1:0]  porta_q;               // Previous port A levels.
    reg [PBC_W-1:0] portbc_q;              // Previous port B/C levels.
    reg             nmi_latch_q;           // Stored NMI edge.
    reg             porta_latch_q;         // Stored vector 1 edge.
    reg             portbc_latch_q;        // Stored vector 2 edge.
    reg [1:0]       ctx_stk_q [0:2];       // Context to return to.
    reg [1:0]       depth_q;               // Nesting depth, max two.
    reg [1:0]       cz_bank_q [0:2];       // Banked carry and zero.
    reg [1:0]       ctx_d;
    reg [11:0]      vec_d;
    reg [2:0]       sel_d;

    wire global_irq_enable   = interrupt_option_reg_q[`MCIC_OPT_GIE_BIT];
    wire portbc_rising_select = interrupt_option_reg_q[`MCIC_OPT_RISE_BIT];
    wire porta_level_select  = interrupt_option_reg_q[`MCIC_OPT_LEVEL_BIT];

    wire nmi_fall = nmi_pin_q & ~i_nmi_pin;
    wire pa_fall  = |(porta_q & ~i_porta_pins);
    wire pa_low   = ~&i_porta_pins;
    wire pbc_edge = portbc_rising_select ?
                    |(~portbc_q & i_portbc_pins) :
                    |(portbc_q & ~i_portbc_pins);

    // Level mode reads the pin live, nothing stored.
    wire req1 = porta_level_select ? pa_low : porta_latch_q;
    wire req2 = portbc_latch_q;
    // Peripheral flags pass only with their enable.
    // Timer zero flag gated by its enable.
    wire req3 = i_timer_zero_flag & i_timer_irq_enable;
    // Conversion complete gated by its enable.
    wire req4 = i_adc_eoc_flag & i_adc_irq_enable;

    // NMI takes any context except NMI; maskables only normal.
    wire nmi_ok  = nmi_latch_q & (o_context_q != `MCIC_CTX_NMI);
    wire mask_ok = (o_context_q == `MCIC_CTX_NORMAL) &
                   (req1 | req2 | req3 | req4);
    // Global enable gates every source, NMI too.
    // Requests accepted only at instruction end.
    assign o_irq_take = i_instr_end & global_irq_enable &
                        (nmi_ok | mask_ok);

    // Pick the vector and new context for an accepted request.
    // The choice is made every cycle but only used when a request is
    // taken, so the defaults below merely keep the logic free of latches.
    // A non-maskable request always wins; among the maskable ones the
    // lowest vector number wins, whatever order they arrived in.
    always @* begin
        ctx_d = `MCIC_CTX_IRQ;
        vec_d = `MCIC_VEC4_ADDR;
        sel_d = 3'h4;
        // Fixed order: NMI, then vector 1 down to 4.
        if (nmi_ok) begin
            ctx_d = `MCIC_CTX_NMI;
            vec_d = `MCIC_VEC0_ADDR;
            sel_d = 3'h0;
        end else if (req1) begin
            vec_d = `MCIC_VEC1_ADDR;
            sel_d = 3'h1;
        end else if (req2) begin
            vec_d = `MCIC_VEC2_ADDR;
            sel_d = 3'h2;
        end else if (req3) begin
            vec_d = `MCIC_VEC3_ADDR;
            sel_d = 3'h3;
        end else begin
            vec_d = `MCIC_VEC4_ADDR;
            sel_d = 3'h4;
        end
    end

    // Option register written at its data address only.
    // The register has no read path; software keeps its own copy, since
    // a read-modify-write bit instruction would only see garbage here.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            interrupt_option_reg_q <= `MCIC_OPT_RESET;
        end else if (i_data_wr && i_data_addr == `MCIC_OPT_ADDR) begin
            interrupt_option_reg_q <= {1'b0,
                i_data_wdata[`MCIC_OPT_LEVEL_BIT:`MCIC_OPT_GIE_BIT], 4'h0};
        end
    end

    // Pin history for edge detection.
    // History resets high, the level of an idle pulled-up pin, so that an
    // idle pin gives no false edge as reset is released. A pin that is low
    // at reset release is read as a falling edge on the first clock.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            nmi_pin_q <= 1'b1;
            porta_q   <= {PA_W{1'b1}};
            portbc_q  <= {PBC_W{1'b1}};
        end else begin
            nmi_pin_q <= i_nmi_pin;
            porta_q   <= i_porta_pins;
            portbc_q  <= i_portbc_pins;
        end
    end

    // Edge latches; a new edge wins over the clear in the same cycle.
    // Letting the set win means an edge that arrives just as its own
    // request is taken is served again later rather than lost; the cost
    // is at most one extra entry into the same routine.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            nmi_latch_q    <= 1'b0;
            porta_latch_q  <= 1'b0;
            portbc_latch_q <= 1'b0;
        end else begin
            // NMI latch cleared as its routine begins.
            if (nmi_fall) begin
                nmi_latch_q <= 1'b1;
            end else if (o_irq_take && sel_d == 3'h0) begin
                nmi_latch_q <= 1'b0;
            end
            // One edge stored; extra edges merge and are lost.
            if (pa_fall && !porta_level_select) begin
                porta_latch_q <= 1'b1;
            end else if ((o_irq_take && sel_d == 3'h1) ||
                         porta_level_select) begin
                porta_latch_q <= 1'b0;
            end
            if (pbc_edge) begin
                portbc_latch_q <= 1'b1;
            end else if (o_irq_take && sel_d == 3'h2) begin
                portbc_latch_q <= 1'b0;
            end
        end
    end

    // Entry and return share one process because both move the context.
    // A take and a return in the same cycle cannot both be honoured; the
    // take wins and the return is dropped, which the core must avoid.
    // The vector load pulse follows the take by one clock so that the
    // vector and the new context are both settled when the core uses them.
    // Entry order: bank switch, push, inhibit, clear, vector.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            // Reset lands in NMI context, nothing to return to.
            o_context_q     <= `MCIC_CTX_NMI;
            depth_q         <= 2'h0;
            o_vector_q      <= 12'h000;
            o_vector_load_q <= 1'b0;
            o_return_load_q <= 1'b0;
            ctx_stk_q[0]    <= `MCIC_CTX_NORMAL;
            ctx_stk_q[1]    <= `MCIC_CTX_NORMAL;
            ctx_stk_q[2]    <= `MCIC_CTX_NORMAL;
        end else begin
            o_vector_load_q <= o_irq_take;
            o_return_load_q <= 1'b0;
            if (o_irq_take) begin
                ctx_stk_q[depth_q] <= o_context_q;
                depth_q            <= depth_q + 2'h1;
                o_context_q        <= ctx_d;
                o_vector_q         <= vec_d;
            end else if (i_return_from_interrupt) begin
                o_return_load_q <= 1'b1;
                if (depth_q != 2'h0) begin
                    o_context_q <= ctx_stk_q[depth_q - 2'h1];
                    depth_q     <= depth_q - 2'h1;
                end else begin
                    // Return from the restart routine goes normal.
                    o_context_q <= `MCIC_CTX_NORMAL;
                end
            end
        end
    end

    // Carry and zero kept per context bank.
    // Writes always go to the bank of the current context, so switching
    // the context alone is enough to save and restore the flags.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            cz_bank_q[0] <= 2'h0;
            cz_bank_q[1] <= 2'h0;
            cz_bank_q[2] <= 2'h0;
        end else if (i_flag_wr) begin
            cz_bank_q[o_context_q] <= {i_carry_in, i_zero_in};
        end
    end
    assign o_carry = cz_bank_q[o_context_q][1];
    assign o_zero  = cz_bank_q[o_context_q][0];

    // Return address stack shared with calls would live in the core.
    mcic_pc_stack #(
        .WIDTH (12),
        .DEPTH (`MCIC_STACK_DEPTH),
        .AW    (3)
    ) u_stack (
        .i_core_clk  (i_core_clk),
        .i_srst      (i_srst),
        .i_push      (o_irq_take),
        .i_pop       (i_return_from_interrupt & ~o_irq_take),
        .i_push_data (i_next_pc),
        .o_top_q     (o_return_pc)
    );
endmodule // mcic_ctrl

// [core/mcic_defs.vh]
// Constants for the microcontroller interrupt controller.
`ifndef MCIC_DEFS_VH
`define MCIC_DEFS_VH
`define MCIC_OPT_ADDR      8'hc8
`define MCIC_OPT_GIE_BIT   4
`define MCIC_OPT_RISE_BIT  5
`define MCIC_OPT_LEVEL_BIT 6
`define MCIC_OPT_RESET     8'h00
`define MCIC_VEC0_ADDR     12'hffc
`define MCIC_VEC1_ADDR     12'hff6
`define MCIC_VEC2_ADDR     12'hff4
`define MCIC_VEC3_ADDR     12'hff2
`define MCIC_VEC4_ADDR     12'hff0
`define MCIC_CTX_NORMAL    2'h0
`define MCIC_CTX_IRQ       2'h1
`define MCIC_CTX_NMI       2'h2
`define MCIC_STACK_DEPTH   6
`endif

// [core/mcic_pc_stack.v]
// Return address stack memory with registered top-of-stack output.
`timescale 1ns/10ps
module mcic_pc_stack #(
    parameter WIDTH = 12,
    parameter DEPTH = 6,
    parameter AW    = 3
) (
    input  wire             i_core_clk,
    input  wire             i_srst,
    input  wire             i_push,
    input  wire             i_pop,
    input  wire [WIDTH-1:0] i_push_data,
    output reg  [WIDTH-1:0] o_top_q
);
    // Storage entries and the count of filled levels.
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    ptr_q;
    integer         k;

    // Push writes the new top; pop loads the removed top into o_top_q.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            ptr_q   <= {AW{1'b0}};
            o_top_q <= {WIDTH{1'b0}};
        end else if (i_push) begin
            // Overflow shifts the oldest entry out, as a true LIFO.
            if ({{(32-AW){1'b0}}, ptr_q} == DEPTH) begin
                for (k = 0; k < DEPTH-1; k = k + 1) begin
                    mem_q[k] <= mem_q[k+1];
                end
                mem_q[DEPTH-1] <= i_push_data;
            end else begin
                mem_q[ptr_q] <= i_push_data;
                ptr_q        <= ptr_q + 1'b1;
            end
            o_top_q <= i_push_data;
        end else if (i_pop) begin
            // The returned address stays in o_top_q for the core.
            if (ptr_q != {AW{1'b0}}) begin
                o_top_q <= mem_q[ptr_q-1'b1];
                ptr_q   <= ptr_q - 1'b1;
            end
        end
    end
endmodule // mcic_pc_stack

// [tb/mcic_core_model.sv]
// Core sequencer model that marks the end of each instruction.
`timescale 1ns/10ps
module mcic_core_model (
    input  wire logic i_core_clk,
    input  wire logic i_srst,
    output logic      o_instr_end
);
    logic [1:0] cnt_q; // Cycle count within the current instruction.
    // instruction end mark
    // Every instruction lasts four cycles and ends on the last one.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            cnt_q       <= 2'h0;
            o_instr_end <= 1'b0;
        end else begin
            cnt_q       <= cnt_q + 2'h1;
            o_instr_end <= (cnt_q == 2'h3);
        end
    end
endmodule // mcic_core_model

// [tb/mcic_ctrl_props.sv]
// Checker for the entry and return timing of the interrupt controller.
`timescale 1ns/10ps
`include "mcic_defs.vh"
module mcic_ctrl_props (
    input wire logic        i_core_clk,
    input wire logic        i_srst,
    input wire logic        i_instr_end,
    input wire logic        i_return_from_interrupt,
    input wire logic        o_irq_take,
    input wire logic [11:0] o_vector_q,
    input wire logic        o_vector_load_q,
    input wire logic        o_return_load_q,
    input wire logic [1:0]  o_context_q
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    // An accepted request followed by its vector load.
    sequence s_entry;
        o_irq_take ##1 o_vector_load_q;
    endsequence
    take_at_end_a: assert property (
        o_irq_take |-> i_instr_end) else $error("take off instruction end");
    entry_load_a: assert property (
        o_irq_take |=> o_vector_load_q) else $error("no vector load");
    load_cause_a: assert property (
        o_vector_load_q |-> $past(o_irq_take)) else $error("stray load");
    entry_ctx_a: assert property (
        s_entry |-> o_context_q != `MCIC_CTX_NORMAL)
        else $error("entry left normal context");
    nmi_ctx_a: assert property (
        o_vector_load_q && o_vector_q == `MCIC_VEC0_ADDR
        |-> o_context_q == `MCIC_CTX_NMI) else $error("nmi context wrong");
    mask_ctx_a: assert property (
        o_vector_load_q && o_vector_q != `MCIC_VEC0_ADDR
        |-> o_context_q == `MCIC_CTX_IRQ) else $error("irq context wrong");
    no_nest_a: assert property (
        o_irq_take && o_context_q == `MCIC_CTX_IRQ
        |=> o_vector_q == `MCIC_VEC0_ADDR) else $error("maskable nested");
    vec_set_a: assert property (
        o_vector_load_q |-> o_vector_q inside {12'hffc, 12'hff6, 12'hff4,
        12'hff2, 12'hff0}) else $error("vector address invalid");
    ret_load_a: assert property (
        i_return_from_interrupt && !o_irq_take |=> o_return_load_q)
        else $error("no return load");
    ret_ctx_a: assert property (
        o_return_load_q |-> o_context_q != `MCIC_CTX_NMI)
        else $error("return stayed in nmi");
endmodule // mcic_ctrl_props
bind mcic_ctrl mcic_ctrl_props mcic_ctrl_props_i (.i_core_clk, .i_srst,
    .i_instr_end, .i_return_from_interrupt, .o_irq_take, .o_vector_q,
    .o_vector_load_q, .o_return_load_q, .o_context_q);

// [tb/tb_top.sv]
// Self-checking bench for the interrupt controller.
`timescale 1ns/10ps
`include "mcic_defs.vh"
module tb_top;
    localparam logic [11:0] ANY = 12'hfff; // Return address not predicted.
    logic clk = 1'b0, srst = 1'b1, nmi = 1'b1, wr = 1'b0, rfi = 1'b0;
    logic tf = 1'b0, te = 1'b0, af = 1'b0, ae = 1'b0, iend;
    logic fw = 1'b0, ci = 1'b0, zi = 1'b0; // Flag bank write and data.
    logic [7:0]  pa = 8'hff, addr = 8'h00, wd = 8'h00, rnd = 8'h44;
    logic [15:0] pbc = 16'hffff;
    logic [11:0] npc = 12'h500, vec, rpc;
    logic        take, vld, rld, car, zer;
    logic [1:0]  ctx;
    logic [14:0] exp_q[$]; // Expected loads: return flag, context, address.
    logic [11:0] stk[$];   // Return addresses the core should hand back.
    int          n_fail = 0, comparisons = 0;
    always #2 clk = ~clk;
    mcic_core_model mcic_core_model_i (.i_core_clk(clk), .i_srst(srst),
        .o_instr_end(iend));
    mcic_ctrl mcic_ctrl_i (.i_core_clk(clk), .i_srst(srst), .i_nmi_pin(nmi),
        .i_porta_pins(pa), .i_portbc_pins(pbc), .i_timer_zero_flag(tf),
        .i_timer_irq_enable(te), .i_adc_eoc_flag(af), .i_adc_irq_enable(ae),
        .i_data_wr(wr), .i_data_addr(addr), .i_data_wdata(wd),
        .i_instr_end(iend), .i_return_from_interrupt(rfi), .i_next_pc(npc),
        .i_flag_wr(fw), .i_carry_in(ci), .i_zero_in(zi),
        .o_irq_take(take), .o_vector_q(vec), .o_vector_load_q(vld),
        .o_return_pc(rpc), .o_return_load_q(rld), .o_carry(car),
        .o_zero(zer), .o_context_q(ctx));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic test_done();
        if (n_fail == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [14:0] got, input logic [14:0] want);
        comparisons++;
        if (got !== want) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask
    // Every vector or return load is compared with the oldest note.
    always @(posedge clk) begin : mon
        logic [14:0] want;
        if (!srst && (vld === 1'b1 || rld === 1'b1)) begin
            want = (exp_q.size() > 0) ? exp_q.pop_front() : 15'h7fff;
            cmp({rld, ctx, (want[11:0] == ANY) ? ANY : (rld ? rpc : vec)},
                want);
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Writes carry and zero into the bank of the current context.
    task automatic set_cz(input logic c, input logic z);
        fw <= 1'b1;
        ci <= c;
        zi <= z;
        tick(1);
        fw <= 1'b0;
    endtask
    // Compares the visible carry and zero away from the clock edge.
    task automatic cmp_cz(input logic [1:0] want);
        @(negedge clk);
        cmp({13'h0, car, zer}, {13'h0, want});
        @(posedge clk);
    endtask
    task automatic wr_at(input logic [7:0] a, input logic [7:0] d);
        wr   <= 1'b1;
        addr <= a;
        wd   <= d;
        tick(1);
        wr   <= 1'b0;
        tick(1);
    endtask
    task automatic ent(input logic [11:0] v, input logic [1:0] c);
        exp_q.push_back({1'b0, c, v});
        stk.push_back(npc);
    endtask
    task automatic ret(input logic [1:0] c);
        exp_q.push_back({1'b1, c, (stk.size() > 0) ? stk.pop_back() : ANY});
        rfi <= 1'b1;
        tick(1);
        rfi <= 1'b0;
    endtask
    // Bounded wait for a return load or a vector load.
    task automatic wt(input logic r);
        int i;
        for (i = 0; i < 64; i++) begin
            @(negedge clk);
            if ((r ? rld : vld) === 1'b1) break;
        end
        @(posedge clk);
        if (i == 64) begin
            n_fail++;
            test_done();
        end
        if (!r) begin
            rnd = lfsr(rnd);
            npc <= {4'h5, rnd};
            tick(1);
        end
    endtask
    initial begin
        tick(20);
        srst <= 1'b0;
        @(negedge clk);
        cmp({13'h0, ctx}, {13'h0, `MCIC_CTX_NMI});
        @(posedge clk);
        set_cz(1'b1, 1'b1);
        ret(`MCIC_CTX_NORMAL);
        wt(1);
        cmp_cz(2'b00);
        set_cz(1'b1, 1'b0);
        nmi <= 1'b0;
        tick(12);
        nmi <= 1'b1;
        ent(`MCIC_VEC0_ADDR, `MCIC_CTX_NMI);
        wr_at(`MCIC_OPT_ADDR, 8'hb0);
        wt(0);
        cmp_cz(2'b11);
        pa  <= 8'hfe;
        pbc <= 16'hfeff;
        tf  <= 1'b1;
        te  <= 1'b1;
        af  <= 1'b1;
        wr_at(8'hc9, 8'h00);
        ret(`MCIC_CTX_NORMAL);
        ent(`MCIC_VEC1_ADDR, `MCIC_CTX_IRQ);
        wt(1);
        wt(0);
        nmi <= 1'b0;
        ent(`MCIC_VEC0_ADDR, `MCIC_CTX_NMI);
        wt(0);
        nmi <= 1'b1;
        pbc <= 16'hffff;
        ret(`MCIC_CTX_IRQ);
        wt(1);
        ret(`MCIC_CTX_NORMAL);
        ent(`MCIC_VEC2_ADDR, `MCIC_CTX_IRQ);
        wt(1);
        wt(0);
        ret(`MCIC_CTX_NORMAL);
        ent(`MCIC_VEC3_ADDR, `MCIC_CTX_IRQ);
        wt(1);
        wt(0);
        tf <= 1'b0;
        ret(`MCIC_CTX_NORMAL);
        wt(1);
        tick(12);
        ent(`MCIC_VEC4_ADDR, `MCIC_CTX_IRQ);
        ae <= 1'b1;
        wt(0);
        af <= 1'b0;
        ret(`MCIC_CTX_NORMAL);
        wt(1);
        ent(`MCIC_VEC1_ADDR, `MCIC_CTX_IRQ);
        wr_at(`MCIC_OPT_ADDR, 8'hd0);
        wt(0);
        pa <= 8'hff;
        ret(`MCIC_CTX_NORMAL);
        wt(1);
        cmp_cz(2'b10);
        tick(8);
        if (exp_q.size() != 0) n_fail++;
        test_done();
    end
endmodule // tb_top
